// file: hw/mtp_core.sv
// Purpose: Energized-hour service timer and average current pulse train.
// Assumes: Speed, restart and current inputs come from logic on this clock.
// Notes: The fine tick is 100 ms; all segment timing is in those ticks.
`timescale 1ns/100ps
module mtp_core
  import mtp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int unsigned HOUR_LEN = HOUR_TICKS,
  parameter logic [15:0] RATED_REF = RST_REF
)
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire mtp_bus_t bus_i,
  output logic [15:0] rdata_o,
  input wire logic const_speed_i,
  input wire logic restart_busy_i,
  input wire logic [15:0] out_current_i,
  output mtp_pins_t pins_o,
  output logic service_alarm_out_o,
  output logic avg_current_pulse_out_o,
  output logic service_due_indication_o,
  output logic nv_save_o,
  output logic [15:0] nv_count_o,
  output logic [6:0] nv_frac_o
);

  ////////////////////////////////////////////////////////////////////////
  // State record.

  typedef struct packed {
    logic [21:0] div;
    logic [15:0] hour_ct;
    logic [6:0] sub;
    logic [15:0] cnt;
    logic [15:0] thr;
    logic [15:0] win;
    logic [15:0] mask;
    logic [15:0] ref_cur;
    logic [15:0] ext;
    logic [7:0] fna;
    logic [7:0] fnb;
    logic [7:0] fnr;
    logic [15:0] rct;
    mtp_st_t st;
    logic [7:0] fc;
    logic [15:0] seg;
    logic [19:0] sum;
    logic [27:0] acc;
    logic [7:0] mw;
    logic prev_cs;
    logic [15:0] rdata;
    logic nv_save;
    logic alarm;
    logic line;
    mtp_pins_t pins;
  } mtp_state_t;

  localparam mtp_state_t S_RST = '{
    div: '0, hour_ct: '0, sub: '0, cnt: RST_CNT, thr: RST_THR,
    win: RST_WIN, mask: RST_MASK, ref_cur: RATED_REF, ext: RST_EXT,
    fna: RST_FN, fnb: RST_FN, fnr: RST_FN, rct: RST_RCT,
    st: ST_IDLE, fc: '0, seg: '0, sum: '0, acc: '0, mw: '0,
    prev_cs: 1'b0, rdata: '0, nv_save: 1'b0, alarm: 1'b0,
    line: 1'b0, pins: '0
  };

  mtp_state_t s;
  mtp_state_t next_s;

  ////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Picks the level that one output terminal shows for its code.
  function automatic logic route(
    input logic [7:0] fn,
    input logic alarm,
    input logic pulse
  );
    logic r;
    r = 1'b0;
    case (fn)
      FN_ALARM: r = alarm;
      FN_ALARM_N: r = ~alarm;
      FN_PULSE: r = pulse;
      FN_PULSE_N: r = ~pulse;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  logic tick;
  logic fend;
  logic entry;
  logic wr_ok;
  logic rst_en;
  logic [27:0] target;
  logic [27:0] step;
  logic [27:0] acc_n;
  logic [15:0] k;
  logic [15:0] d_cnt;
  logic [7:0] mwidth;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // One pass computes the whole next record from the current one.
  always_comb
  begin
    next_s = s;
    next_s.nv_save = 1'b0;
    next_s.rdata = 16'h0000;
    next_s.prev_cs = const_speed_i;
    tick = (s.div == 22'(TICK_CYCLES - 1));
    fend = tick && (s.fc == FRAME_T - 8'h01);
    entry = const_speed_i && !s.prev_cs;
    wr_ok = (s.ext == 16'h0000);
    rst_en = (s.rct != RCT_OFF);
    // Comparing k*ref*win against sum*gain avoids any divider.
    target = 28'(s.sum) * 28'(CUR_GAIN);
    step = 28'(s.ref_cur) * 28'(s.win);
    acc_n = s.acc + step;
    k = s.seg + 16'h0001;
    d_cnt = s.cnt - KNEE_LO;
    // Seven seconds over 560 counts is exactly one tick per eight.
    if (s.cnt < KNEE_LO)
    begin
      mwidth = MNT_MIN_T;
    end
    else if (s.cnt > KNEE_HI)
    begin
      mwidth = MNT_MAX_T;
    end
    else
    begin
      mwidth = MNT_MIN_T + d_cnt[10:3];
    end
    next_s.div = tick ? 22'h0 : s.div + 22'h1;

    // Hour accumulation; only completed hours count.
    if (tick)
    begin
      if (s.hour_ct == 16'(HOUR_LEN - 1))
      begin
        next_s.hour_ct = 16'h0000;
        next_s.nv_save = 1'b1;
        if (s.sub == SUB_LAST)
        begin
          next_s.sub = 7'h00;
          if (s.cnt < CNT_MAX)
          begin
            next_s.cnt = s.cnt + 16'h0001;
          end
        end
        else
        begin
          next_s.sub = s.sub + 7'h01;
        end
      end
      else
      begin
        next_s.hour_ct = s.hour_ct + 16'h0001;
      end
    end

    // Register writes; counter and parameter writes take effect only while ext is zero.
    if (bus_i.wr)
    begin
      case (bus_i.addr)
        OFF_CNT:
        begin
          if (wr_ok && bus_i.wdata == 16'h0000)
          begin
            next_s.cnt = 16'h0000;
            next_s.sub = 7'h00;
            next_s.hour_ct = 16'h0000;
          end
        end
        OFF_THR:
        begin
          if (wr_ok && bus_i.wdata <= ALARM_OFF)
          begin
            next_s.thr = bus_i.wdata;
          end
        end
        OFF_WIN:
        begin
          if (wr_ok && bus_i.wdata != 16'h0000 &&
              bus_i.wdata <= WIN_MAX_T)
          begin
            next_s.win = bus_i.wdata;
          end
        end
        OFF_MASK:
        begin
          if (wr_ok && bus_i.wdata <= MASK_MAX_T)
          begin
            next_s.mask = bus_i.wdata;
          end
        end
        OFF_REF:
        begin
          if (wr_ok && bus_i.wdata <= REF_MAX)
          begin
            next_s.ref_cur = bus_i.wdata;
          end
        end
        OFF_EXT: next_s.ext = bus_i.wdata;
        OFF_FNA: next_s.fna = bus_i.wdata[7:0];
        OFF_FNB: next_s.fnb = bus_i.wdata[7:0];
        OFF_FNR:
        begin
          // The relay cannot follow a pulse train, so that code is refused.
          if (bus_i.wdata[7:0] != FN_PULSE &&
              bus_i.wdata[7:0] != FN_PULSE_N)
          begin
            next_s.fnr = bus_i.wdata[7:0];
          end
        end
        OFF_RCT: next_s.rct = bus_i.wdata;
        default: next_s.rct = s.rct;
      endcase
    end

    // Register reads; unmapped addresses return zero.
    if (bus_i.rd)
    begin
      case (bus_i.addr)
        OFF_CNT: next_s.rdata = s.cnt;
        OFF_THR: next_s.rdata = s.thr;
        OFF_WIN: next_s.rdata = s.win;
        OFF_MASK: next_s.rdata = s.mask;
        OFF_REF: next_s.rdata = s.ref_cur;
        OFF_EXT: next_s.rdata = s.ext;
        OFF_FNA: next_s.rdata = {8'h00, s.fna};
        OFF_FNB: next_s.rdata = {8'h00, s.fnb};
        OFF_FNR: next_s.rdata = {8'h00, s.fnr};
        OFF_RCT: next_s.rdata = s.rct;
        OFF_STAT: next_s.rdata = {5'h00, s.st, s.line, s.alarm};
        default: next_s.rdata = 16'h0000;
      endcase
    end

    // Frame position advances on every tick inside a frame.
    if (s.st != ST_IDLE && s.st != ST_MASK && tick)
    begin
      next_s.fc = fend ? 8'h00 : s.fc + 8'h01;
    end

    // Pulse sequencer.
    case (s.st)
      ST_IDLE:
      begin
        if (entry)
        begin
          next_s.st = ST_MASK;
          next_s.seg = 16'h0000;
        end
      end
      ST_MASK:
      begin
        if (!const_speed_i)
        begin
          next_s.st = ST_IDLE;
        end
        else if (tick)
        begin
          if (s.seg >= s.mask)
          begin
            next_s.fc = 8'h00;
            next_s.seg = 16'h0000;
            next_s.sum = 20'h0;
            if (rst_en && restart_busy_i)
            begin
              next_s.st = ST_NODATA;
            end
            else
            begin
              next_s.st = ST_START;
            end
          end
          else
          begin
            next_s.seg = s.seg + 16'h0001;
          end
        end
      end
      ST_START:
      begin
        if (!const_speed_i)
        begin
          next_s.st = ST_INVH;
        end
        else if (tick)
        begin
          if (16'(s.fc) < s.win)
          begin
            next_s.sum = s.sum + 20'(out_current_i);
          end
          if (s.fc == START_T - 8'h01)
          begin
            next_s.st = ST_LOWC;
            next_s.seg = 16'h0000;
            next_s.acc = 28'h0;
          end
        end
      end
      ST_LOWC:
      begin
        if (tick)
        begin
          next_s.seg = k;
          next_s.acc = acc_n;
          // Minimum width first, then the ratio, capped at the maximum.
          if ((k >= 16'(LOW_MIN_T) && acc_n >= target) ||
              k == 16'(LOW_MAX_T))
          begin
            next_s.st = ST_HIGHM;
            next_s.seg = 16'h0000;
            next_s.mw = mwidth;
          end
        end
      end
      ST_HIGHM:
      begin
        if (tick)
        begin
          next_s.seg = k;
          if (k == 16'(s.mw))
          begin
            next_s.st = ST_TAIL;
          end
        end
      end
      ST_INVH:
      begin
        if (tick && s.fc == INV_HI_T - 8'h01)
        begin
          next_s.st = ST_INVL;
        end
      end
      ST_TAIL, ST_INVL, ST_NODATA:
      begin
        // Speed changes are ignored here so the frame runs out.
        if (fend)
        begin
          next_s.sum = 20'h0;
          if (out_current_i == 16'h0000)
          begin
            next_s.st = ST_IDLE;
          end
          else if (!const_speed_i)
          begin
            // One empty frame, then wait for a fresh constant speed.
            next_s.st = (s.st == ST_NODATA) ? ST_IDLE : ST_NODATA;
          end
          else if (rst_en && restart_busy_i)
          begin
            next_s.st = ST_NODATA;
          end
          else
          begin
            next_s.st = ST_START;
          end
        end
      end
      default: next_s.st = ST_IDLE;
    endcase

    // Registered outputs follow the next state.
    next_s.line = (next_s.st == ST_START) || (next_s.st == ST_HIGHM) ||
      (next_s.st == ST_INVH);
    next_s.alarm = (next_s.thr != ALARM_OFF) &&
      (next_s.cnt >= next_s.thr);
    next_s.pins.term_a = route(next_s.fna, next_s.alarm, next_s.line);
    next_s.pins.term_b = route(next_s.fnb, next_s.alarm, next_s.line);
    next_s.pins.relay = route(next_s.fnr, next_s.alarm, 1'b0);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register.

  // The whole record resets to constants.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s <= S_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from the record.
  assign rdata_o = s.rdata;
  assign pins_o = s.pins;
  assign service_alarm_out_o = s.alarm;
  assign service_due_indication_o = s.alarm;
  assign avg_current_pulse_out_o = s.line;
  assign nv_save_o = s.nv_save;
  assign nv_count_o = s.cnt;
  assign nv_frac_o = s.sub;

endmodule // mtp_core

// file: hw/mtp_pkg.sv
// Purpose: Constants and types of the service timer and current pulse.
// Assumes: 40 MHz clock, 100 ms fine tick, currents in 0.1 A units.
// Notes:
// Contract
// - Count whole hours, save hourly, show hundreds.
// - Partial hours never add to the total.
// - Counter saturates at its maximum, never wraps.
// - Counter read-only; writing zero clears it.
// - Alarm when counter reaches threshold; 9999 disables.
// - Panel shows service indication with alarm.
// - Terminal code 95/195 routes the alarm.
// - Pulse code 93/193 only on transistor terminals.
// - Pulse frames repeat, fixed 20 s length.
// - Mask time after reaching constant speed.
// - One second start pulse; average during window.
// - Low width is avg/ref times 5 s, clamped.
// - Reference current sets the 100 percent point.
// - High pulse 2 to 9 s encodes counter.
// - No mask or sampling while speed changes.
// - Speed change in start pulse: invalid frame.
// - A started frame always completes.
// - Zero current at frame end stops frames.
// - Data-less low frame in three listed cases.
// - Monitor parameters writable regardless of protection.
// - Parameters settable only when display select zero.
package mtp_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned FINE_TICK_MS = 100;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * FINE_TICK_MS;
  localparam int unsigned HOUR_S = 3600;
  localparam int unsigned HOUR_TICKS = HOUR_S * 1000 / FINE_TICK_MS;
  // Segment times in ms, then in fine ticks.
  localparam int unsigned FRAME_MS = 20000;
  localparam int unsigned START_MS = 1000;
  localparam int unsigned LOW_MIN_MS = 500;
  localparam int unsigned LOW_MAX_MS = 9000;
  localparam int unsigned CUR_SCALE_MS = 5000;
  localparam int unsigned MNT_MIN_MS = 2000;
  localparam int unsigned MNT_MAX_MS = 9000;
  localparam int unsigned INV_HI_MS = 3500;
  localparam int unsigned MASK_MAX_MS = 20000;
  localparam logic [7:0] FRAME_T = 8'(FRAME_MS / FINE_TICK_MS);
  localparam logic [7:0] START_T = 8'(START_MS / FINE_TICK_MS);
  localparam logic [7:0] LOW_MIN_T = 8'(LOW_MIN_MS / FINE_TICK_MS);
  localparam logic [7:0] LOW_MAX_T = 8'(LOW_MAX_MS / FINE_TICK_MS);
  localparam logic [7:0] CUR_GAIN = 8'(CUR_SCALE_MS / FINE_TICK_MS);
  localparam logic [7:0] MNT_MIN_T = 8'(MNT_MIN_MS / FINE_TICK_MS);
  localparam logic [7:0] MNT_MAX_T = 8'(MNT_MAX_MS / FINE_TICK_MS);
  localparam logic [7:0] INV_HI_T = 8'(INV_HI_MS / FINE_TICK_MS);
  localparam logic [15:0] MASK_MAX_T = 16'(MASK_MAX_MS / FINE_TICK_MS);
  localparam logic [15:0] WIN_MAX_T = 16'(START_T);
  // Counter limits in 100 h units; knees at 16000 h and 72000 h.
  localparam logic [15:0] CNT_MAX = 16'h270e;
  localparam logic [15:0] ALARM_OFF = 16'h270f;
  localparam logic [6:0] SUB_LAST = 7'h63;
  localparam logic [15:0] KNEE_LO = 16'h00a0;
  localparam logic [15:0] KNEE_HI = 16'h02d0;
  localparam logic [15:0] REF_MAX = 16'h1388;
  localparam logic [15:0] RCT_OFF = 16'h270f;
  // Output terminal function codes.
  localparam logic [7:0] FN_ALARM = 8'h5f;
  localparam logic [7:0] FN_ALARM_N = 8'hc3;
  localparam logic [7:0] FN_PULSE = 8'h5d;
  localparam logic [7:0] FN_PULSE_N = 8'hc1;
  // Register offsets.
  localparam logic [7:0] OFF_CNT = 8'h00;
  localparam logic [7:0] OFF_THR = 8'h04;
  localparam logic [7:0] OFF_WIN = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0c;
  localparam logic [7:0] OFF_REF = 8'h10;
  localparam logic [7:0] OFF_EXT = 8'h14;
  localparam logic [7:0] OFF_FNA = 8'h18;
  localparam logic [7:0] OFF_FNB = 8'h1c;
  localparam logic [7:0] OFF_FNR = 8'h20;
  localparam logic [7:0] OFF_RCT = 8'h24;
  localparam logic [7:0] OFF_STAT = 8'h28;
  // Reset values.
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [15:0] RST_THR = ALARM_OFF;
  localparam logic [15:0] RST_WIN = WIN_MAX_T;
  localparam logic [15:0] RST_MASK = 16'h0000;
  localparam logic [15:0] RST_REF = 16'h0032;
  localparam logic [15:0] RST_EXT = 16'h0000;
  localparam logic [7:0] RST_FN = 8'h00;
  localparam logic [15:0] RST_RCT = RCT_OFF;

  typedef enum logic [8:0] {
    ST_IDLE = 9'b0_0000_0001,
    ST_MASK = 9'b0_0000_0010,
    ST_START = 9'b0_0000_0100,
    ST_LOWC = 9'b0_0000_1000,
    ST_HIGHM = 9'b0_0001_0000,
    ST_TAIL = 9'b0_0010_0000,
    ST_INVH = 9'b0_0100_0000,
    ST_INVL = 9'b0_1000_0000,
    ST_NODATA = 9'b1_0000_0000
  } mtp_st_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } mtp_bus_t;

  typedef struct packed {
    logic term_a;
    logic term_b;
    logic relay;
  } mtp_pins_t;
endpackage

// file: testbench/mtp_core_sva.sv
// Purpose: Port-level checks of the service timer and pulse line.
// Assumes: Shortened tick and hour parameters handed on by the bind.
// Notes: Only the top module's ports are watched.
`timescale 1ns/100ps
module mtp_core_sva
  import mtp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int unsigned HOUR_LEN = HOUR_TICKS
)
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire mtp_bus_t bus_i,
  input wire logic service_alarm_out_o,
  input wire logic avg_current_pulse_out_o,
  input wire logic service_due_indication_o,
  input wire logic nv_save_o,
  input wire logic [15:0] nv_count_o,
  input wire logic [6:0] nv_frac_o
);
  logic [15:0] hi_cnt;
  logic [15:0] lo_cnt;
  logic [15:0] gap;
  logic seen;
  logic fseen;
  logic clr_wr;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // A clearing write restarts the hour phase, so gap checks wait a save.
  assign clr_wr = bus_i.wr && bus_i.addr == OFF_CNT && bus_i.wdata == '0;

  // Run lengths of the pulse line and spacing of hour saves.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hi_cnt <= '0;
      lo_cnt <= '0;
      gap <= '0;
      seen <= 1'b0;
      fseen <= 1'b0;
    end
    else
    begin
      hi_cnt <= avg_current_pulse_out_o ? hi_cnt + 16'h0001 : '0;
      lo_cnt <= avg_current_pulse_out_o ? '0 : lo_cnt + 16'h0001;
      gap <= nv_save_o ? '0 : gap + 16'h0001;
      seen <= clr_wr ? 1'b0 : (nv_save_o | seen);
      fseen <= fseen | !avg_current_pulse_out_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_ind;
    service_due_indication_o == service_alarm_out_o;
  endproperty
  a_ind: assert property (p_ind)
    else $error("indication differs from alarm");
  property p_cnt_max;
    nv_count_o <= CNT_MAX;
  endproperty
  a_cnt_max: assert property (p_cnt_max)
    else $error("counter above maximum");
  property p_cnt_step;
    $changed(nv_count_o) |->
      nv_count_o == $past(nv_count_o) + 16'h0001 || nv_count_o == '0;
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("counter moved by other than one");
  property p_frac;
    nv_frac_o <= SUB_LAST;
  endproperty
  a_frac: assert property (p_frac)
    else $error("sub-hundred hours out of range");
  property p_save_gap;
    nv_save_o && seen |-> gap == HOUR_LEN * TICK_CYCLES - 1;
  endproperty
  a_save_gap: assert property (p_save_gap)
    else $error("hour save spacing wrong");
  property p_save_pulse;
    nv_save_o |=> !nv_save_o;
  endproperty
  a_save_pulse: assert property (p_save_pulse)
    else $error("hour save longer than one cycle");
  property p_hi_min;
    $fell(avg_current_pulse_out_o) |-> hi_cnt >= START_T * TICK_CYCLES;
  endproperty
  a_hi_min: assert property (p_hi_min)
    else $error("high segment too short");
  property p_hi_max;
    hi_cnt <= MNT_MAX_T * TICK_CYCLES;
  endproperty
  a_hi_max: assert property (p_hi_max)
    else $error("high segment too long");
  property p_lo_min;
    $rose(avg_current_pulse_out_o) && fseen |->
      lo_cnt >= LOW_MIN_T * TICK_CYCLES;
  endproperty
  a_lo_min: assert property (p_lo_min)
    else $error("low segment too short");
  property p_alarm_cause;
    $rose(service_alarm_out_o) |-> $past(bus_i.wr) || $past(bus_i.wr, 2)
      || $past(bus_i.wr, 3) || nv_count_o != $past(nv_count_o, 3);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause)
    else $error("alarm rose without cause");
endmodule // mtp_core_sva

bind mtp_core mtp_core_sva #(
  .TICK_CYCLES(TICK_CYCLES),
  .HOUR_LEN(HOUR_LEN)
) u_sva (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .bus_i(bus_i),
  .service_alarm_out_o(service_alarm_out_o),
  .avg_current_pulse_out_o(avg_current_pulse_out_o),
  .service_due_indication_o(service_due_indication_o),
  .nv_save_o(nv_save_o),
  .nv_count_o(nv_count_o),
  .nv_frac_o(nv_frac_o)
);

// file: testbench/mtp_plc_model.sv
// Purpose: Controller input that times each level of the pulse line.
// Assumes: Line sampled on the same clock, no filtering.
// Notes: Reports every segment when the level changes.
`timescale 1ns/100ps
module mtp_plc_model
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic line_i,
  output logic seg_done_o,
  output logic seg_level_o,
  output logic [15:0] seg_len_o
);
  logic prev;
  logic [15:0] cnt;

  // Width of each segment in clocks, handed out at its end.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prev <= 1'b0;
      cnt <= '0;
      seg_done_o <= 1'b0;
      seg_level_o <= 1'b0;
      seg_len_o <= '0;
    end
    else
    begin
      prev <= line_i;
      seg_done_o <= line_i != prev;
      if (line_i != prev)
      begin
        seg_level_o <= prev;
        seg_len_o <= cnt;
        cnt <= 16'h0001;
      end
      else
        cnt <= cnt + 16'h0001;
    end
  end
endmodule // mtp_plc_model

// file: testbench/mtp_core_tb_top.sv
// Purpose: Self-checking bench of the service timer and pulse train.
// Assumes: Tick of 4 clocks and hour of 3 ticks to keep the run short.
// Notes: Expected reads and segments are queued and checked by monitors.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) \
  begin \
    checks_done++; \
    if ((gt) !== (ex)) \
    begin \
      err_total++; \
      $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); \
    end \
  end
module mtp_core_tb_top;
  import mtp_pkg::*;
  localparam int TC = 4;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  mtp_bus_t bus = '0;
  logic cs = 1'b0;
  logic rb = 1'b0;
  logic [15:0] cur = '0;
  logic [15:0] rdata;
  logic [15:0] slen;
  logic [15:0] re;
  logic [16:0] se;
  mtp_pins_t pins;
  logic alarm, line, ind, sdone, slvl;
  logic pend = 1'b0;
  logic [16:0] sq[$];
  logic [15:0] rq[$];
  logic [7:0] fc [4] = '{FN_PULSE, FN_PULSE_N, FN_ALARM, FN_ALARM_N};
  logic [3:0] fx = 4'b0110;
  logic [31:0] rnd = 32'h0000_4df0;
  int err_total = 0;
  int checks_done = 0;
  int seg_seen = 0;
  int n;
  int b;

  always #12.5 sys_clk_i = ~sys_clk_i;

  mtp_core #(.TICK_CYCLES(TC), .HOUR_LEN(3)) dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
    .const_speed_i(cs), .restart_busy_i(rb), .out_current_i(cur),
    .pins_o(pins), .service_alarm_out_o(alarm),
    .avg_current_pulse_out_o(line), .service_due_indication_o(ind),
    .nv_save_o(), .nv_count_o(), .nv_frac_o());

  mtp_plc_model plc (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .line_i(pins.term_a), .seg_done_o(sdone), .seg_level_o(slvl),
    .seg_len_o(slen));

  ////////////////////////////////////////////////////////////////////////////
  // Read data stand only in the cycle after the strobe; segments at once.
  always @(negedge sys_clk_i)
  begin
    if (pend)
    begin
      re = rq.pop_front();
      `CHK("rdata", re, rdata)
    end
    pend = bus.rd;
    if (sdone && sq.size() == 0)
      `CHK("segment", 17'h0_0000, {slvl, slen})
    else if (sdone)
    begin
      se = sq.pop_front();
      seg_seen++;
      if (se[15:0] != '0)
        `CHK("segment", se, {slvl, slen})
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task bw(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge sys_clk_i);
    bus.wr <= 1'b0;
  endtask

  task br(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk_i);
    bus.rd <= 1'b1;
    bus.addr <= a;
    rq.push_back(e);
    @(posedge sys_clk_i);
    bus.rd <= 1'b0;
  endtask

  // Bounded wait for the controller to have timed k segments.
  task wseg(input int k);
    for (int i = 0; i < 3000 && seg_seen < k; i++)
      @(posedge sys_clk_i);
    if (seg_seen < k)
      `CHK("seg_wait", k, seg_seen)
  endtask

  // Two frames, or one frame then a restart data-less frame, then idle.
  task frames(input logic [15:0] c, input logic rs);
    logic [15:0] l;
    l = (c + 16'h0001) >> 1;
    if (l < 16'(LOW_MIN_T))
      l = 16'(LOW_MIN_T);
    if (l > 16'(LOW_MAX_T))
      l = 16'(LOW_MAX_T);
    b = seg_seen;
    @(posedge sys_clk_i);
    cur <= c;
    cs <= 1'b1;
    sq.push_back(17'h0_0000);
    sq.push_back({1'b1, 16'(START_T * TC)});
    sq.push_back({1'b0, 16'(l * TC)});
    sq.push_back({1'b1, 16'(MNT_MIN_T * TC)});
    if (rs)
    begin
      wseg(b + 2);
      bw(OFF_RCT, 16'h0005);
      rb <= 1'b1;
      wseg(b + 4);
      repeat (400) @(posedge sys_clk_i);
      br(OFF_STAT, 16'h0400);
    end
    else
    begin
      sq.push_back({1'b0, 16'((FRAME_T - START_T - l - MNT_MIN_T) * TC)});
      sq.push_back({1'b1, 16'(START_T * TC)});
      sq.push_back({1'b0, 16'(l * TC)});
      sq.push_back({1'b1, 16'(MNT_MIN_T * TC)});
      wseg(b + 6);
    end
    cur <= '0;
    rb <= 1'b0;
    wseg(b + (rs ? 4 : 8));
    repeat (1000) @(posedge sys_clk_i);
    br(OFF_STAT, 16'h0004);
    cs <= 1'b0;
  endtask

  task stop_test;
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: registers, hour counter and alarm, terminals, frames.
  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    br(OFF_THR, RST_THR);
    br(OFF_WIN, 16'h000a);
    br(OFF_MASK, 16'h0000);
    br(OFF_REF, RST_REF);
    br(OFF_CNT, 16'h0000);
    br(8'h30, 16'h0000);
    bw(OFF_WIN, 16'h000b);
    br(OFF_WIN, 16'h000a);
    bw(OFF_EXT, 16'h0001);
    bw(OFF_REF, 16'h0077);
    br(OFF_REF, RST_REF);
    bw(OFF_EXT, 16'h0000);
    bw(OFF_REF, 16'h0064);
    br(OFF_REF, 16'h0064);
    bw(OFF_THR, 16'h0001);
    bw(OFF_CNT, 16'h0000);
    // Polled on the falling edge so the alarm is settled when looked at.
    for (n = 0; n < 1400 && alarm !== 1'b1; n++)
      @(negedge sys_clk_i);
    `CHK("alarm_time", 1'b1, (n >= 1190 && n <= 1215))
    `CHK("indication", 1'b1, ind)
    br(OFF_CNT, 16'h0001);
    bw(OFF_CNT, 16'h0005);
    br(OFF_CNT, 16'h0001);
    bw(OFF_FNR, {8'h00, FN_PULSE});
    br(OFF_FNR, 16'h0000);
    bw(OFF_FNR, {8'h00, FN_ALARM});
    br(OFF_FNR, {8'h00, FN_ALARM});
    repeat (2) @(negedge sys_clk_i);
    `CHK("relay", 1'b1, pins.relay)
    bw(OFF_FNB, {8'h00, FN_PULSE_N});
    repeat (2) @(negedge sys_clk_i);
    `CHK("term_b", 1'b1, pins.term_b)
    sq.push_back(17'h0_0000);
    sq.push_back(17'h0_0000);
    for (int i = 0; i < 4; i++)
    begin
      bw(OFF_FNA, {8'h00, fc[i]});
      repeat (2) @(negedge sys_clk_i);
      `CHK("term_a", fx[i], pins.term_a)
    end
    bw(OFF_FNA, {8'h00, FN_PULSE});
    bw(OFF_THR, ALARM_OFF);
    repeat (3) @(negedge sys_clk_i);
    `CHK("alarm_off", 1'b0, alarm)
    rnd = xs(rnd);
    frames(16'h0014 + 16'(rnd % 160), 1'b0);
    frames(16'h0005, 1'b0);
    frames(16'h0190, 1'b1);
    // Speed change inside the start pulse gives the invalid frame.
    b = seg_seen;
    @(posedge sys_clk_i);
    cur <= 16'h0064;
    cs <= 1'b1;
    sq.push_back(17'h0_0000);
    sq.push_back({1'b1, 16'(INV_HI_T * TC)});
    wseg(b + 1);
    repeat (8) @(posedge sys_clk_i);
    cs <= 1'b0;
    wseg(b + 2);
    repeat (400) @(posedge sys_clk_i);
    br(OFF_STAT, 16'h0200);
    repeat (600) @(posedge sys_clk_i);
    br(OFF_STAT, 16'h0400);
    repeat (1000) @(posedge sys_clk_i);
    br(OFF_STAT, 16'h0004);
    // Speed lost inside a long mask drops back to idle with no frame.
    bw(OFF_MASK, 16'h0014);
    cs <= 1'b1;
    repeat (40) @(posedge sys_clk_i);
    br(OFF_STAT, 16'h0008);
    cs <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    br(OFF_STAT, 16'h0004);
    // Restart still busy when the mask ends gives a data-less frame.
    rb <= 1'b1;
    cs <= 1'b1;
    repeat (120) @(posedge sys_clk_i);
    br(OFF_STAT, 16'h0400);
    cs <= 1'b0;
    rb <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    stop_test();
  end

  // Watchdog sized well above the roughly 10000 cycles of the sequence.
  initial
  begin
    #(40000 * 25);
    err_total++;
    $display("MISMATCH watchdog exp done got hang");
    stop_test();
  end
endmodule // mtp_core_tb_top
